/* fsc_pkg.sv */
// Summary of operation
// R1 - read-mode bit: 0 single reads, 1 page
// R2 - host writes zeros to reserved config bits
// R3 - status output mode holds until reconfigured/reset
// R4 - default status output is ready/busy level
// R5 - configuration command, then code next write
// R6 - code bit0 erase pulse, bit1 program pulse
// R7 - code zero restores ready/busy level mode
// R8 - configure only when idle, not suspended; the host checks only the status ready bit (bit 7)
// R9 - read ready flag before configuring
// R10 - invalid code sets both error flags
// R11 - pulse modes give one ~250 ns low pulse
// R12 - reset pin low: device off, outputs floating
// R13 - after reset device uses page read mode
// R14 - reset during program/erase aborts it
// R15 - status and identifier reads are single reads
// R16 - one pulse per enabled finished operation
`default_nettype none
package fsc_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WP_NS = 70;
    localparam int T_WPH_NS = 30;
    localparam int T_ACC_NS = 150;
    localparam int T_OFF_NS = 15;
    localparam int T_RST_LOW_NS = 35000;
    localparam int T_RST_REC_NS = 1000;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_REC_CYC = (T_RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    localparam int ADDR_W = 24;
    localparam int DQ_W = 16;
    localparam int APB_ADDR_W = 8;
    localparam int CMD_W = 8;

    localparam logic [APB_ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [APB_ADDR_W-1:0] REG_ADDR = 8'h04;
    localparam logic [APB_ADDR_W-1:0] REG_WDATA = 8'h08;
    localparam logic [APB_ADDR_W-1:0] REG_CMD = 8'h0C;
    localparam logic [APB_ADDR_W-1:0] REG_RDATA = 8'h10;
    localparam logic [APB_ADDR_W-1:0] REG_STAT = 8'h14;
    localparam logic [APB_ADDR_W-1:0] REG_IRQ_STAT = 8'h18;
    localparam logic [APB_ADDR_W-1:0] REG_IRQ_MASK = 8'h1C;
    localparam logic [APB_ADDR_W-1:0] REG_RDCFG = 8'h20;

    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam int CMD_STAT_LSB = 0;
    localparam int CMD_CFG_LSB = 8;
    localparam int CMD_RDCFG_SETUP_LSB = 16;
    localparam int CMD_RDCFG_CONF_LSB = 24;
    localparam int OP_W = 3;

    localparam int SR_PGM_ERR_BIT = 4;
    localparam int SR_ERS_ERR_BIT = 5;
    localparam int SR_READY_BIT = 7;
    localparam int RDCFG_PAGE_BIT = 16;
    localparam int PIN_MODE_W = 2;
    localparam logic [PIN_MODE_W-1:0] PIN_LEVEL_MODE = 2'h0;

    localparam int STAT_BUSY = 0;
    localparam int STAT_PIN_LVL = 1;
    localparam int STAT_MODE_LSB = 2;
    localparam int STAT_PAGE = 4;
    localparam int STAT_PLEN_LSB = 8;
    localparam int PLEN_W = 8;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_CFG_ERR = 2;
    localparam int IRQ_COMPLETE = 3;
    localparam int IRQ_ABORT = 4;
    localparam int IRQ_W = 5;

    typedef enum logic [OP_W-1:0] {
        OP_CFG_PIN, OP_SET_RDCFG, OP_RESET, OP_WRITE, OP_READ
    } fsc_op_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
    } fsc_pins_t;

    typedef struct packed {
        logic is_read;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] data;
    } fsc_req_t;

    localparam fsc_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        dq_oe: 1'b0, addr: '0, dq: '0};
endpackage : fsc_pkg
`default_nettype wire

/* fsc_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module fsc_cycle import fsc_pkg::*; #(
    parameter int WP_C = WP_CYC,
    parameter int WPH_C = WPH_CYC,
    parameter int ACC_C = ACC_CYC,
    parameter int OFF_C = OFF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire fsc_req_t req_in,
    input wire logic [DQ_W-1:0] dq_in,
    output fsc_pins_t pins_out,
    output logic done_out,
    output logic [DQ_W-1:0] rdata_out
);
    typedef enum logic [1:0] {C_IDLE, C_PULSE, C_HOLD} fsc_cyc_t;
    fsc_cyc_t state_ff;
    logic rd_ff;
    logic [CNT_W-1:0] cnt_ff;

    wire cnt_zero = (cnt_ff == '0);

    // single read cycles only: page bursts would break status reads
    always_ff @(posedge ref_clk_in or posedge rst_in) begin // R15
        if (rst_in) begin
            state_ff <= C_IDLE;
            pins_out <= PINS_IDLE;
            rd_ff <= 1'b0;
            cnt_ff <= '0;
            done_out <= 1'b0;
            rdata_out <= '0;
        end else begin
            done_out <= 1'b0;
            unique case (state_ff)
                C_IDLE: if (req_valid_in) begin
                    pins_out.addr <= req_in.addr;
                    pins_out.ce_n <= 1'b0;
                    pins_out.oe_n <= ~req_in.is_read;
                    pins_out.we_n <= req_in.is_read;
                    pins_out.dq <= req_in.data;
                    pins_out.dq_oe <= ~req_in.is_read;
                    rd_ff <= req_in.is_read;
                    cnt_ff <= req_in.is_read ? CNT_W'(ACC_C - 1) : CNT_W'(WP_C - 1);
                    state_ff <= C_PULSE;
                end
                C_PULSE: if (cnt_zero) begin
                    pins_out.ce_n <= 1'b1;
                    pins_out.oe_n <= 1'b1;
                    pins_out.we_n <= 1'b1;
                    if (rd_ff) begin
                        rdata_out <= dq_in;
                    end
                    cnt_ff <= rd_ff ? CNT_W'(OFF_C - 1) : CNT_W'(WPH_C - 1);
                    state_ff <= C_HOLD;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
                // data held past the rising strobe, released with the gap
                C_HOLD: if (cnt_zero) begin
                    pins_out.dq_oe <= 1'b0;
                    done_out <= 1'b1;
                    state_ff <= C_IDLE;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            endcase
        end
    end
endmodule : fsc_cycle
`default_nettype wire

/* fsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fsc_host import fsc_pkg::*; #(
    parameter int RST_LOW_C = RST_LOW_CYC,
    parameter int RST_REC_C = RST_REC_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [APB_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    output fsc_pins_t flash_pins_out,
    input wire logic [DQ_W-1:0] flash_dq_in,
    output logic reset_powerdown_n_out,
    input wire logic ready_event_output_in
);
    typedef enum logic [3:0] {
        M_IDLE, M_PRE_CMD, M_PRE_RD, M_CFG_CMD, M_CFG_CODE, M_POST_CMD, M_POST_RD,
        M_RDCFG_SETUP, M_RDCFG_CONF, M_WR, M_RD, M_RST_LOW, M_RST_REC
    } fsc_state_t;

    fsc_state_t state_ff, nxt_state;
    logic issued_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [31:0] wdata_ff;
    logic [31:0] cmd_ff;
    logic rdcfg_page_ff;
    logic page_mirror_ff;
    logic [PIN_MODE_W-1:0] pin_mode_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic pin_prev_ff;
    logic [PLEN_W-1:0] low_cnt_ff;
    logic [PLEN_W-1:0] pulse_len_ff;
    logic eng_done;
    logic [DQ_W-1:0] eng_rdata;
    fsc_req_t eng_req;

    // apb: answer one cycle into the access phase, commit on the completing edge
    wire apb_acc = psel_in & penable_in & ~pready_out;
    wire apb_done = psel_in & penable_in & pready_out;
    wire apb_wr = apb_done & pwrite_in;
    wire sel_ctrl = (paddr_in == REG_CTRL);
    wire sel_addr = (paddr_in == REG_ADDR);
    wire sel_wdata = (paddr_in == REG_WDATA);
    wire sel_cmd = (paddr_in == REG_CMD);
    wire sel_rdata = (paddr_in == REG_RDATA);
    wire sel_stat = (paddr_in == REG_STAT);
    wire sel_irq_stat = (paddr_in == REG_IRQ_STAT);
    wire sel_irq_mask = (paddr_in == REG_IRQ_MASK);
    wire sel_rdcfg = (paddr_in == REG_RDCFG);
    wire addr_hit = sel_ctrl | sel_addr | sel_wdata | sel_cmd | sel_rdata | sel_stat
        | sel_irq_stat | sel_irq_mask | sel_rdcfg;

    wire busy = (state_ff != M_IDLE);
    wire [31:0] stat_word = {16'h0000, pulse_len_ff, 3'h0, page_mirror_ff, pin_mode_ff,
        ready_event_output_in, busy};
    wire [31:0] rd_mux = sel_ctrl ? 32'(state_ff) :
        sel_addr ? 32'(addr_ff) :
        sel_wdata ? wdata_ff :
        sel_cmd ? cmd_ff :
        sel_rdata ? 32'(eng_rdata) :
        sel_stat ? stat_word :
        sel_irq_stat ? 32'(irq_stat_ff) :
        sel_irq_mask ? 32'(irq_mask_ff) :
        sel_rdcfg ? 32'(rdcfg_page_ff) : 32'h0000_0000;

    // a start while busy is dropped; software polls the busy bit first
    wire op_start = apb_wr & sel_ctrl & ~busy;
    wire [OP_W-1:0] op_code = pwdata_in[OP_W-1:0];

    // engine requests: one per bus state, re-armed by the engine's done
    wire bus_state = busy & (state_ff != M_RST_LOW) & (state_ff != M_RST_REC);
    wire req_valid = bus_state & ~issued_ff;
    wire is_rd = (state_ff == M_PRE_RD) | (state_ff == M_POST_RD) | (state_ff == M_RD);
    wire is_rdcfg = (state_ff == M_RDCFG_SETUP) | (state_ff == M_RDCFG_CONF);
    wire [ADDR_W-1:0] rdcfg_addr = ADDR_W'(rdcfg_page_ff) << RDCFG_PAGE_BIT; // R2
    wire [DQ_W-1:0] stat_cmd = DQ_W'(cmd_ff[CMD_STAT_LSB +: CMD_W]);
    wire [DQ_W-1:0] cfg_cmd = DQ_W'(cmd_ff[CMD_CFG_LSB +: CMD_W]);
    wire [DQ_W-1:0] rdcfg_setup = DQ_W'(cmd_ff[CMD_RDCFG_SETUP_LSB +: CMD_W]);
    wire [DQ_W-1:0] rdcfg_conf = DQ_W'(cmd_ff[CMD_RDCFG_CONF_LSB +: CMD_W]);
    wire pre_post_cmd = (state_ff == M_PRE_CMD) | (state_ff == M_POST_CMD);
    assign eng_req.is_read = is_rd;
    assign eng_req.addr = is_rdcfg ? rdcfg_addr : addr_ff;
    assign eng_req.data = pre_post_cmd ? stat_cmd :
        (state_ff == M_CFG_CMD) ? cfg_cmd :
        (state_ff == M_CFG_CODE) ? wdata_ff[DQ_W-1:0] :
        (state_ff == M_RDCFG_SETUP) ? rdcfg_setup :
        (state_ff == M_RDCFG_CONF) ? rdcfg_conf : wdata_ff[DQ_W-1:0];

    fsc_cycle u_cycle (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .req_valid_in(req_valid),
        .req_in(eng_req),
        .dq_in(flash_dq_in),
        .pins_out(flash_pins_out),
        .done_out(eng_done),
        .rdata_out(eng_rdata)
    );

    wire dev_ready = eng_rdata[SR_READY_BIT];
    wire both_err = eng_rdata[SR_PGM_ERR_BIT] & eng_rdata[SR_ERS_ERR_BIT];
    wire pre_done = (state_ff == M_PRE_RD) & eng_done;
    wire post_done = (state_ff == M_POST_RD) & eng_done;
    wire rst_done = (state_ff == M_RST_REC) & (cnt_ff == '0);
    wire cnt_zero = (cnt_ff == '0);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            M_IDLE: if (op_start) begin
                unique case (op_code)
                    OP_CFG_PIN: nxt_state = M_PRE_CMD;
                    OP_SET_RDCFG: nxt_state = M_RDCFG_SETUP;
                    OP_RESET: nxt_state = M_RST_LOW;
                    OP_WRITE: nxt_state = M_WR;
                    OP_READ: nxt_state = M_RD;
                    default: nxt_state = M_IDLE;
                endcase
            end
            M_PRE_CMD: if (eng_done) nxt_state = M_PRE_RD;
            // configure only from an idle machine, seen in the status read
            M_PRE_RD: if (eng_done) nxt_state = dev_ready ? M_CFG_CMD : M_IDLE; // R8 R9
            M_CFG_CMD: if (eng_done) nxt_state = M_CFG_CODE; // R5
            M_CFG_CODE: if (eng_done) nxt_state = M_POST_CMD;
            M_POST_CMD: if (eng_done) nxt_state = M_POST_RD;
            M_POST_RD: if (eng_done) nxt_state = M_IDLE;
            M_RDCFG_SETUP: if (eng_done) nxt_state = M_RDCFG_CONF;
            M_RDCFG_CONF, M_WR, M_RD: if (eng_done) nxt_state = M_IDLE;
            M_RST_LOW: if (cnt_zero) nxt_state = M_RST_REC;
            M_RST_REC: if (cnt_zero) nxt_state = M_IDLE;
        endcase
    end

    wire enter_low = (state_ff != M_RST_LOW) & (nxt_state == M_RST_LOW);
    wire enter_rec = (state_ff == M_RST_LOW) & (nxt_state == M_RST_REC);
    wire [CNT_W-1:0] nxt_cnt = enter_low ? CNT_W'(RST_LOW_C - 1) :
        enter_rec ? CNT_W'(RST_REC_C - 1) :
        cnt_zero ? cnt_ff : cnt_ff - 1'b1;

    // status pin: rising edge ends a busy level or a completion pulse
    wire pin_rise = ready_event_output_in & ~pin_prev_ff & reset_powerdown_n_out;
    wire pulse_mode = (pin_mode_ff != PIN_LEVEL_MODE);
    wire [PLEN_W-1:0] nxt_low_cnt = ready_event_output_in ? '0 :
        (&low_cnt_ff) ? low_cnt_ff : low_cnt_ff + 1'b1;

    // busy level on the pin at reset start (level mode only) means the running operation is lost
    wire abort_evt = enter_low & ~ready_event_output_in & ~pulse_mode; // R14
    wire [IRQ_W-1:0] irq_set;
    assign irq_set[IRQ_DONE] = busy & (nxt_state == M_IDLE);
    assign irq_set[IRQ_REFUSED] = pre_done & ~dev_ready;
    assign irq_set[IRQ_CFG_ERR] = post_done & both_err; // R10
    assign irq_set[IRQ_COMPLETE] = pin_rise; // R16
    assign irq_set[IRQ_ABORT] = abort_evt;
    // clear only what the read returned, so a same-edge set survives
    wire [IRQ_W-1:0] irq_clr = (apb_done & ~pwrite_in & sel_irq_stat) ?
        prdata_out[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

    // mode mirror: valid code kept until next accepted code or reset
    wire [PIN_MODE_W-1:0] nxt_pin_mode = rst_done ? PIN_LEVEL_MODE : // R3 R4
        (post_done & ~both_err) ? wdata_ff[PIN_MODE_W-1:0] : pin_mode_ff; // R6 R7
    wire nxt_page_mirror = rst_done ? 1'b1 : // R13
        ((state_ff == M_RDCFG_CONF) & eng_done) ? rdcfg_page_ff : page_mirror_ff; // R1

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= apb_acc;
            pslverr_out <= apb_acc & ~addr_hit;
            prdata_out <= apb_acc ? rd_mux : '0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_ff <= '0;
            wdata_ff <= '0;
            cmd_ff <= CMD_RESET;
            rdcfg_page_ff <= 1'b0;
            irq_mask_ff <= '0;
        end else begin
            if (apb_wr & sel_addr) addr_ff <= pwdata_in[ADDR_W-1:0];
            if (apb_wr & sel_wdata & ~busy) wdata_ff <= pwdata_in;
            if (apb_wr & sel_cmd) cmd_ff <= pwdata_in;
            if (apb_wr & sel_rdcfg) rdcfg_page_ff <= pwdata_in[0];
            if (apb_wr & sel_irq_mask) irq_mask_ff <= pwdata_in[IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= M_IDLE;
            issued_ff <= 1'b0;
            cnt_ff <= '0;
            reset_powerdown_n_out <= 1'b1;
            pin_mode_ff <= PIN_LEVEL_MODE;
            page_mirror_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            issued_ff <= (issued_ff | req_valid) & ~eng_done;
            cnt_ff <= nxt_cnt;
            reset_powerdown_n_out <= (nxt_state != M_RST_LOW); // R12
            pin_mode_ff <= nxt_pin_mode;
            page_mirror_ff <= nxt_page_mirror;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_ff <= '0;
            irq_out <= 1'b0;
            pin_prev_ff <= 1'b1;
            low_cnt_ff <= '0;
            pulse_len_ff <= '0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_out <= |(nxt_irq_stat & irq_mask_ff);
            pin_prev_ff <= ready_event_output_in;
            low_cnt_ff <= nxt_low_cnt;
            if (pin_rise & pulse_mode) pulse_len_ff <= low_cnt_ff; // R11
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    wire was_pre_rd = (state_ff == M_PRE_RD);
    wire in_cfg_cmd = (state_ff == M_CFG_CMD);

    property p_rdcfg_reserved_zero; // R2
        (req_valid && is_rdcfg) |=> (!flash_pins_out.we_n
            && flash_pins_out.addr[RDCFG_PAGE_BIT-1:1] == '0
            && flash_pins_out.addr[RDCFG_PAGE_BIT] == rdcfg_page_ff);
    endproperty
    a_rdcfg_reserved_zero: assert property (p_rdcfg_reserved_zero) // R2
        else $error("reserved read-config address bits not zero");

    property p_code_follows_cmd; // R5
        (in_cfg_cmd && eng_done) |=> (state_ff == M_CFG_CODE && req_valid)
            ##1 (!flash_pins_out.we_n && flash_pins_out.dq == wdata_ff[DQ_W-1:0]);
    endproperty
    a_code_follows_cmd: assert property (p_code_follows_cmd) // R5
        else $error("configuration code not in the next write cycle");

    property p_cfg_only_ready; // R8
        (was_pre_rd && eng_done) |=> (in_cfg_cmd == $past(dev_ready));
    endproperty
    a_cfg_only_ready: assert property (p_cfg_only_ready) // R8
        else $error("configuration started without a ready status");

    property p_status_before_cfg; // R9
        $rose(in_cfg_cmd) |-> $past(was_pre_rd) && !flash_pins_out.dq_oe;
    endproperty
    a_status_before_cfg: assert property (p_status_before_cfg) // R9
        else $error("configuration not preceded by a status read");

    c_cfg_done: cover property (post_done && !both_err);
    c_cfg_refused: cover property (pre_done && !dev_ready);
    c_reset_walk: cover property (enter_low ##[1:1000] !reset_powerdown_n_out);
    c_pin_pulse: cover property (pin_rise && pulse_mode);
endmodule : fsc_host
`default_nettype wire

/* fsc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model import fsc_pkg::*; #(
    parameter logic [7:0] STAT_CMD = 8'h21,
    parameter logic [7:0] CFG_CMD = 8'h32,
    parameter logic [7:0] SETUP_CMD = 8'h43,
    parameter logic [7:0] CONF_CMD = 8'h54,
    parameter int PULSE_CYC = 63
) (
    input wire logic ref_clk_in,
    input wire fsc_pins_t pins_in,
    input wire logic reset_powerdown_n_in,
    input wire logic busy_in,
    input wire logic erase_done_in,
    input wire logic prog_done_in,
    output logic [DQ_W-1:0] dq_out,
    output logic evt_pin_out,
    output logic page_out
);
    logic we_q_ff = 1'b1;
    logic cfg_next_ff = 1'b0;
    logic setup_next_ff = 1'b0;
    logic pgm_err_ff = 1'b0;
    logic ers_err_ff = 1'b0;
    logic aborted_ff = 1'b0;
    logic [1:0] mode_ff = 2'h0;
    logic [7:0] pulse_ff = 8'h00;
    logic [DQ_W-1:0] last_ff = 16'h0000;
    wire logic we_rise = pins_in.we_n & ~we_q_ff;
    wire logic [7:0] cmd = pins_in.dq[7:0];
    wire logic reading = ~pins_in.ce_n & ~pins_in.oe_n & reset_powerdown_n_in;
    wire logic [DQ_W-1:0] status = {8'h00, ~busy_in, 1'b0, ers_err_ff, pgm_err_ff, 4'h0};
    wire logic evt = (erase_done_in & mode_ff[0]) | (prog_done_in & mode_ff[1]);
    // released bus shows a toggling pattern so a stale value never passes
    assign dq_out = reading ? status : ~last_ff;
    logic page_ff = 1'b1;
    assign evt_pin_out = ~reset_powerdown_n_in ? 1'b1 :
        (mode_ff == 2'h0) ? ~busy_in : (pulse_ff == 8'h00);
    assign page_out = page_ff;
    always @(posedge ref_clk_in or negedge reset_powerdown_n_in) begin
        if (!reset_powerdown_n_in) begin
            mode_ff <= 2'h0;
            page_ff <= 1'b1;
            pgm_err_ff <= 1'b0;
            ers_err_ff <= 1'b0;
            cfg_next_ff <= 1'b0;
            setup_next_ff <= 1'b0;
            pulse_ff <= 8'h00;
            aborted_ff <= aborted_ff | busy_in;
        end else begin
            we_q_ff <= pins_in.we_n;
            last_ff <= (reading === 1'b1) ? status : ~last_ff;
            if (pulse_ff != 8'h00) begin
                pulse_ff <= pulse_ff - 8'h01;
            end else if (evt) begin
                pulse_ff <= 8'(PULSE_CYC);
            end
            if (we_rise) begin
                cfg_next_ff <= (cmd == CFG_CMD);
                setup_next_ff <= (cmd == SETUP_CMD);
                if (cfg_next_ff && pins_in.dq > 16'h0003) begin
                    pgm_err_ff <= 1'b1;
                    ers_err_ff <= 1'b1;
                end else if (cfg_next_ff) begin
                    mode_ff <= pins_in.dq[1:0];
                end
                if (setup_next_ff && cmd == CONF_CMD) begin
                    page_ff <= pins_in.addr[RDCFG_PAGE_BIT];
                end
            end
        end
    end
endmodule : fsc_flash_model
`default_nettype wire

/* flash_status_pin_config_reset_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_status_pin_config_reset_tb import fsc_pkg::*;;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, irq, rp_n, evt_pin, page, e;
    logic busy = 1'b0, erase_done = 1'b0, prog_done = 1'b0;
    fsc_pins_t pins;
    logic [DQ_W-1:0] dev_dq;
    wire logic [DQ_W-1:0] flash_dq = pins.dq_oe ? pins.dq : dev_dq;
    int fail_count = 0;
    int samples_checked = 0;
    logic [15:0] codes [4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0000};
    always #2 ref_clk_in = ~ref_clk_in;
    fsc_host #(.RST_LOW_C(20), .RST_REC_C(5)) DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .irq_out(irq), .flash_pins_out(pins), .flash_dq_in(flash_dq),
        .reset_powerdown_n_out(rp_n), .ready_event_output_in(evt_pin));
    fsc_flash_model model (.ref_clk_in(ref_clk_in), .pins_in(pins),
        .reset_powerdown_n_in(rp_n), .busy_in(busy), .erase_done_in(erase_done),
        .prog_done_in(prog_done), .dq_out(dev_dq), .evt_pin_out(evt_pin), .page_out(page));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        // answer read at the edge itself, before that edge's updates land
        @(posedge ref_clk_in);
        while (pready !== 1'b1) @(posedge ref_clk_in);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic run_op(input logic [2:0] op, input logic [15:0] wd);
        int i;
        apb(1'b1, REG_WDATA, {16'h0000, wd});
        apb(1'b1, REG_CTRL, {29'h0, op});
        q = 32'h0000_0001;
        for (i = 0; i < 600 && q[STAT_BUSY] !== 1'b0; i++) apb(1'b0, REG_STAT, 32'h0);
    endtask : run_op
    task automatic irq_chk(input string n, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk(n, x, q & m);
    endtask : irq_chk
    task automatic event_pulse(input logic er, input logic pg);
        @(posedge ref_clk_in);
        erase_done <= er;
        prog_done <= pg;
        @(posedge ref_clk_in);
        erase_done <= 1'b0;
        prog_done <= 1'b0;
        repeat (90) @(posedge ref_clk_in);
    endtask : event_pulse
    initial begin
        repeat (15000) @(posedge ref_clk_in);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        apb(1'b0, REG_STAT, 32'h0);
        chk("stat_after_reset", 32'h0000_0002, q & 32'h0000_000F);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
        apb(1'b1, REG_CMD, 32'h5443_3221);
        apb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
        apb(1'b1, REG_RDCFG, 32'h0000_0000);
        run_op(3'h1, 16'h0000);
        apb(1'b0, REG_STAT, 32'h0);
        chk("page_mirror", 32'h0, {31'h0, q[STAT_PAGE]});
        chk("device_page", 32'h0, {31'h0, page});
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("irq_raised", 32'h1, {31'h0, irq});
        irq_chk("irq_done", 32'h0000_0001, 32'h0000_0001);
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        apb(1'b1, REG_IRQ_MASK, 32'h0000_0000);
        apb(1'b1, REG_RDCFG, 32'h0000_0001);
        run_op(3'h1, 16'h0000);
        apb(1'b0, REG_STAT, 32'h0);
        chk("page_mirror_set", 32'h1, {31'h0, q[STAT_PAGE]});
        chk("device_page_set", 32'h1, {31'h0, page});
        foreach (codes[k]) begin
            run_op(3'h0, codes[k]);
            apb(1'b0, REG_STAT, 32'h0);
            chk("mode_mirror", {30'h0, codes[k][1:0]}, {30'h0, q[3:2]});
            irq_chk("cfg_done", 32'h0000_0007, 32'h0000_0001);
            event_pulse(1'b1, 1'b0);
            irq_chk("erase_pulse", 32'h0000_0008, {28'h0, codes[k][0], 3'h0});
            apb(1'b0, REG_STAT, 32'h0);
            if (codes[k][0]) chk("pulse_len", 32'd63, {24'h0, q[15:8]});
            event_pulse(1'b0, 1'b1);
            irq_chk("prog_pulse", 32'h0000_0008, {28'h0, codes[k][1], 3'h0});
        end
        apb(1'b1, REG_RDCFG, 32'h0000_0000);
        run_op(3'h1, 16'h0000);
        run_op(3'h0, 16'h0005);
        irq_chk("bad_code", 32'h0000_0004, 32'h0000_0004);
        busy <= 1'b1;
        run_op(3'h0, 16'h0001);
        irq_chk("cfg_refused", 32'h0000_0002, 32'h0000_0002);
        run_op(3'h2, 16'h0000);
        irq_chk("reset_abort", 32'h0000_0010, 32'h0000_0010);
        apb(1'b0, REG_STAT, 32'h0);
        chk("post_reset_stat", 32'h0000_0010, q & 32'h0000_001C);
        chk("device_page_reset", 32'h1, {31'h0, page});
        busy <= 1'b0;
        run_op(3'h0, 16'h0002);
        irq_chk("errors_cleared", 32'h0000_0004, 32'h0000_0000);
        apb(1'b0, REG_STAT, 32'h0);
        chk("mode_program", 32'h2, {30'h0, q[3:2]});
        run_op(3'h2, 16'h0000);
        apb(1'b0, REG_STAT, 32'h0);
        chk("mode_after_reset", 32'h0, {30'h0, q[3:2]});
        complete_run();
    end
endmodule : flash_status_pin_config_reset_tb
`default_nettype wire
